// *** hdl/nvw_cfg.svh ***
// Constants of the data nonvolatile write controller: register word indices,
// field positions, reset values, unlock keys and timing counts.
// Assumes a 100 MHz core clock and a 32-bit classic Wishbone register port.
`ifndef NVW_CFG_SVH
`define NVW_CFG_SVH

// ====================================================================
// Register word indices, byte address is four times the index.
`define NVW_IDX_DATA 3'h0
`define NVW_IDX_ADDR 3'h1
`define NVW_IDX_CTRL 3'h2
`define NVW_IDX_UNLOCK 3'h3
`define NVW_IDX_PFLAG 3'h4
`define NVW_IDX_PENABLE 3'h5
`define NVW_IDX_GICTRL 3'h6

// ====================================================================
// Field positions and masks.
`define NVW_CTL_RD 0
`define NVW_CTL_WR 1
`define NVW_CTL_PERMIT 2
`define NVW_CTL_ABORT 3
`define NVW_FLAG_DONE 7
`define NVW_PERIPH_MASK 8'hef
`define NVW_RST_BYTE 8'h00

// ====================================================================
// Unlock keys and the exact gap count at an accepted key step, which lies three cycles after the step before.
`define NVW_KEY1 8'h55
`define NVW_KEY2 8'haa
`define NVW_KEY_GAP 4'h2

// ====================================================================
// Timing: times in their own unit, cycle counts derived from the rate.
`define NVW_CLK_MHZ 100
`define NVW_POR_TIME_MS 64
`define NVW_POR_CYCLES (`NVW_POR_TIME_MS * 1000 * `NVW_CLK_MHZ)
`define NVW_PROG_TIME_US 4
`define NVW_PROG_CYCLES (`NVW_PROG_TIME_US * `NVW_CLK_MHZ)
`define NVW_POR_CW 23
`define NVW_PROG_CW 16
`define NVW_GAP_CW 4

`endif

// *** hdl/nvw_pkg.sv ***
// Types of the data nonvolatile write controller; its array does not import them.
// Assumes nvw_cfg.svh supplies the counter widths.
`include "nvw_cfg.svh"

package nvw_pkg;

   // =================================================================
   // Unlock detector states.
   typedef enum logic [1:0] {UNL_IDLE, UNL_KEY1, UNL_KEY2} nvw_unl_e;

   // =================================================================
   // Whole state of the controller, registered as one value.
   typedef struct packed {
      logic ack;
      logic [31:0] rdat;
      logic [7:0] data;
      logic [7:0] addr;
      logic permit;
      logic wtrig;
      logic rtrig;
      logic abort;
      logic [7:0] pflag;
      logic [7:0] penable;
      logic [7:0] gictrl;
      nvw_unl_e unl;
      logic [`NVW_GAP_CW-1:0] gap;
      logic [`NVW_PROG_CW-1:0] prog_cnt;
      logic [`NVW_POR_CW-1:0] por_cnt;
      logic por_done;
      logic [7:0] paddr_s1;
      logic [7:0] paddr_s2;
      logic [7:0] prdat;
   } nvw_st_s;

endpackage

// *** hdl/nvw_array.sv ***
// Byte array of the data nonvolatile store, held in flip-flops.
// Assumes one write strobe from the controller and two combinational reads.
`timescale 1ns/1ps

module nvw_array #(
   parameter int DEPTH = 256,
   parameter int WIDTH = 8
) (
   input wire logic sys_clk_i,
   input wire logic we_i,
   input wire logic [$clog2(DEPTH)-1:0] waddr_i,
   input wire logic [WIDTH-1:0] wdata_i,
   input wire logic [$clog2(DEPTH)-1:0] raddr_i,
   output logic [WIDTH-1:0] rdata_o,
   input wire logic [$clog2(DEPTH)-1:0] praddr_i,
   output logic [WIDTH-1:0] prdata_o
);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] cells;
   } nvw_arr_s;

   nvw_arr_s st_r;
   nvw_arr_s st_nxt;

   // =================================================================
   // Contents survive every reset, as a nonvolatile store must.
   always_comb
   begin
      st_nxt = st_r;
      if (we_i)
      begin
         st_nxt.cells[waddr_i] = wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i)
   begin
      st_r <= st_nxt;
   end

   // Both read ports look at the stored cells directly.
   assign rdata_o = st_r.cells[raddr_i];
   assign prdata_o = st_r.cells[praddr_i];

endmodule // nvw_array

// *** hdl/nvw_ctrl.sv ***
// Write and read control of the data nonvolatile store, with its registers.
// Assumes a classic Wishbone master on sys_clk_i, warm resets from logic on
// the same clock, and a programmer address that arrives from outside.
//
// Design decisions made here: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "nvw_cfg.svh"

module nvw_ctrl
   import nvw_pkg::*;
#(
   parameter int POR_CYCLES = `NVW_POR_CYCLES,
   parameter int PROG_CYCLES = `NVW_PROG_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic ext_rst_i,
   input wire logic watchdog_rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic data_protect_fuse_i,
   input wire logic [7:0] prog_addr_i,
   output logic [7:0] prog_rdata_o
);

   // =================================================================
   // Refuse counts that the counters cannot hold.
   // The power-up counter is sized for 64 ms at 100 MHz with little to spare.
   if (POR_CYCLES < 1 || POR_CYCLES >= (1 << `NVW_POR_CW))
   begin : g_bad_por
      $error("POR_CYCLES out of range");
   end
   if (PROG_CYCLES < 1 || PROG_CYCLES >= (1 << `NVW_PROG_CW))
   begin : g_bad_prog
      $error("PROG_CYCLES out of range");
   end

   localparam logic [`NVW_POR_CW-1:0] POR_LAST = `NVW_POR_CW'(POR_CYCLES - 1);
   localparam logic [`NVW_PROG_CW-1:0] PROG_LAST = `NVW_PROG_CW'(PROG_CYCLES - 1);

   nvw_st_s st_r;
   nvw_st_s st_nxt;
   logic [7:0] arr_rdata;
   logic [7:0] arr_prdata;
   logic arr_we;
   logic req;
   logic commit;
   logic wr;
   logic warm_rst;
   logic prog_end;
   logic [2:0] idx;
   logic [7:0] wbyte;
   logic [7:0] ctrl_rd;
   logic [31:0] rd_mux;

   // =================================================================
   // Bus decode. A write commits at the edge where ack is seen high.
   // The one wait state puts every effect on an edge where the master still holds the request.
   assign req = wb_cyc_i & wb_stb_i;
   assign commit = req & st_r.ack;
   assign wr = commit & wb_we_i & wb_sel_i[0];
   assign idx = wb_adr_i[4:2];
   assign wbyte = wb_dat_i[7:0];
   assign warm_rst = ext_rst_i | watchdog_rst_i;
   assign prog_end = st_r.wtrig & (st_r.prog_cnt == PROG_LAST);
   assign ctrl_rd = {4'h0, st_r.abort, st_r.permit, st_r.wtrig, st_r.rtrig};

   // Read multiplexer; unmapped words answer with zero.
   // Zero rather than an alias keeps software probes of the map from seeing live state.
   always_comb
   begin
      rd_mux = 32'h0;
      case (idx)
         `NVW_IDX_DATA: rd_mux = {24'h0, st_r.data};
         `NVW_IDX_ADDR: rd_mux = {24'h0, st_r.addr};
         `NVW_IDX_CTRL: rd_mux = {24'h0, ctrl_rd};
         `NVW_IDX_UNLOCK: rd_mux = 32'h0;
         `NVW_IDX_PFLAG: rd_mux = {24'h0, st_r.pflag};
         `NVW_IDX_PENABLE: rd_mux = {24'h0, st_r.penable};
         `NVW_IDX_GICTRL: rd_mux = {24'h0, st_r.gictrl};
         default: rd_mux = 32'h0;
      endcase
   end

   // =================================================================
   // Next state of the whole controller.
   // Later blocks override earlier ones, so warm reset is written last and wins.
   always_comb
   begin
      st_nxt = st_r;
      arr_we = 1'b0;
      st_nxt.ack = 1'b0;
      // The programmer address comes from a pin and passes two flops first.
      st_nxt.paddr_s1 = prog_addr_i;
      st_nxt.paddr_s2 = st_r.paddr_s1;
      // A fused part hides the array from the programmer only.
      st_nxt.prdat = data_protect_fuse_i ? arr_prdata : 8'h00;

      // Registered ack, one cycle after the request, dropped the next.
      if (req && !st_r.ack)
      begin
         st_nxt.ack = 1'b1;
         st_nxt.rdat = rd_mux;
      end

      // Power-up timer; writes stay blocked until it has run out.
      if (!st_r.por_done)
      begin
         st_nxt.por_cnt = st_r.por_cnt + `NVW_POR_CW'(1);
         st_nxt.por_done = (st_r.por_cnt == POR_LAST);
      end

      // Read trigger: data lands one cycle later and the bit clears.
      if (st_r.rtrig)
      begin
         st_nxt.data = arr_rdata;
         st_nxt.rtrig = 1'b0;
      end

      // Self-timed write; nothing but its own count or a warm reset ends it, permit included.
      if (st_r.wtrig)
      begin
         st_nxt.prog_cnt = st_r.prog_cnt + `NVW_PROG_CW'(1);
         if (prog_end)
         begin
            arr_we = 1'b1;
            st_nxt.wtrig = 1'b0;
         end
      end

      // The detector ages and falls back to idle once the window passes.
      // A step is taken only when gap reads exactly KEY_GAP at its commit edge,
      // which is what two-cycle requests with one idle cycle between them give; faster or slower
      // software is refused, so the sequence must not be split by other code.
      if (st_r.unl != UNL_IDLE)
      begin
         if (st_r.gap != {`NVW_GAP_CW{1'b1}})
         begin
            st_nxt.gap = st_r.gap + `NVW_GAP_CW'(1);
         end
         if (st_r.gap > `NVW_KEY_GAP)
         begin
            st_nxt.unl = UNL_IDLE;
         end
      end

      // Any committed access other than an accepted key step resets it, the write start included.
      if (commit)
      begin
         st_nxt.unl = UNL_IDLE;
      end

      // Register writes, low byte lane only.
      // The upper lanes have no storage behind them and are dropped.
      if (wr)
      begin
         case (idx)
            `NVW_IDX_DATA: st_nxt.data = wbyte;
            `NVW_IDX_ADDR: st_nxt.addr = wbyte;
            `NVW_IDX_CTRL:
            begin
               st_nxt.permit = wbyte[`NVW_CTL_PERMIT];
               st_nxt.abort = wbyte[`NVW_CTL_ABORT];
               // Ones start an operation; zeros leave triggers alone.
               if (wbyte[`NVW_CTL_RD])
               begin
                  st_nxt.rtrig = 1'b1;
               end
               if (wbyte[`NVW_CTL_WR] && st_r.permit && st_r.por_done && !st_r.wtrig
                   && st_r.unl == UNL_KEY2 && st_r.gap == `NVW_KEY_GAP)
               begin
                  st_nxt.wtrig = 1'b1;
                  st_nxt.prog_cnt = '0;
               end
            end
            `NVW_IDX_UNLOCK:
            begin
               // No storage here: the byte only steps the detector.
               if (wbyte == `NVW_KEY1)
               begin
                  st_nxt.unl = UNL_KEY1;
                  st_nxt.gap = '0;
               end
               else if (wbyte == `NVW_KEY2 && st_r.unl == UNL_KEY1
                        && st_r.gap == `NVW_KEY_GAP)
               begin
                  st_nxt.unl = UNL_KEY2;
                  st_nxt.gap = '0;
               end
            end
            `NVW_IDX_PFLAG: st_nxt.pflag = wbyte & `NVW_PERIPH_MASK;
            `NVW_IDX_PENABLE: st_nxt.penable = wbyte & `NVW_PERIPH_MASK;
            `NVW_IDX_GICTRL: st_nxt.gictrl = wbyte;
            default: st_nxt.pflag = st_nxt.pflag;
         endcase
      end

      // Completion sets the done flag even against a clearing write.
      if (prog_end)
      begin
         st_nxt.pflag[`NVW_FLAG_DONE] = 1'b1;
      end

      // Warm reset: registers to their reset values, abort kept or set.
      // The power-up timer keeps running, so a warm reset never reopens that window.
      if (warm_rst)
      begin
         arr_we = 1'b0;
         st_nxt.abort = st_r.abort | st_r.wtrig;
         st_nxt.data = `NVW_RST_BYTE;
         st_nxt.addr = `NVW_RST_BYTE;
         st_nxt.permit = 1'b0;
         st_nxt.wtrig = 1'b0;
         st_nxt.rtrig = 1'b0;
         st_nxt.pflag = `NVW_RST_BYTE;
         st_nxt.penable = `NVW_RST_BYTE;
         st_nxt.gictrl = `NVW_RST_BYTE;
         st_nxt.unl = UNL_IDLE;
         st_nxt.ack = 1'b0;
      end
   end

   // =================================================================
   // Power-on reset clears everything, write permit and timer included.
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   // =================================================================
   // Array; the write uses address and data as they stand at the end.
   // Software may change both while the write runs; the last value is stored.
   nvw_array #(
      .DEPTH(256),
      .WIDTH(8)
   ) u_array (
      .sys_clk_i(sys_clk_i),
      .we_i(arr_we),
      .waddr_i(st_r.addr),
      .wdata_i(st_r.data),
      .raddr_i(st_r.addr),
      .rdata_o(arr_rdata),
      .praddr_i(st_r.paddr_s2),
      .prdata_o(arr_prdata)
   );

   assign wb_dat_o = st_r.rdat;
   assign wb_ack_o = st_r.ack;
   assign prog_rdata_o = st_r.prdat;

   // =================================================================
   // Checks on the controller's own behaviour.
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   AST_KEY_ORDER: assert property ($rose(st_r.wtrig) |-> $past(st_r.unl) == UNL_KEY2)
      else $error("write started without both keys");
   AST_GAP_EXACT: assert property ($rose(st_r.wtrig) |-> $past(st_r.gap) == `NVW_KEY_GAP)
      else $error("write started with wrong cycle distance");
   AST_PERMIT_NEEDED: assert property ($rose(st_r.wtrig) |-> $past(st_r.permit))
      else $error("write started without permit");
   AST_PERMIT_HW: assert property ($changed(st_r.permit) |->
         $past(wr && idx == `NVW_IDX_CTRL) || $past(warm_rst))
      else $error("permit changed without a write or reset");
   AST_RUN_ON: assert property (st_r.wtrig && !prog_end && !warm_rst |=> st_r.wtrig)
      else $error("write cycle ended early");
   AST_DONE_SET: assert property (prog_end && !warm_rst |=>
         !st_r.wtrig && st_r.pflag[`NVW_FLAG_DONE])
      else $error("write end did not set done");
   AST_DONE_STICKY: assert property ($fell(st_r.pflag[`NVW_FLAG_DONE]) |->
         $past(wr && idx == `NVW_IDX_PFLAG) || $past(warm_rst))
      else $error("done flag cleared by hardware");
   AST_POR_BLOCK: assert property (st_r.wtrig |-> st_r.por_done)
      else $error("write during power-up interval");
   AST_READ_NEXT: assert property (st_r.rtrig && !warm_rst |=>
         !st_r.rtrig && st_r.data == $past(arr_rdata))
      else $error("read trigger did not load data");
   AST_UNLOCK_ZERO: assert property (req && !st_r.ack && idx == `NVW_IDX_UNLOCK |=>
         wb_ack_o && wb_dat_o == 32'h0)
      else $error("unlock register read not zero");
   AST_ABORT: assert property (warm_rst && st_r.wtrig |=>
         st_r.abort && st_r.addr == 8'h00 && st_r.data == 8'h00)
      else $error("warm reset during write not recorded");

   // Refusals and side paths that the scenarios above do not pin down.
   AST_ZERO_IGNORED: assert property (wr && idx == `NVW_IDX_CTRL &&
         !wbyte[`NVW_CTL_WR] && st_r.wtrig && !prog_end && !warm_rst |=> st_r.wtrig)
      else $error("zero write cleared the write trigger");
   AST_UNL_DROP: assert property (commit && st_r.unl == UNL_KEY2 |=>
         st_r.unl != UNL_KEY2)
      else $error("unlock state survived another access");
   AST_DONE_CAUSE: assert property ($rose(st_r.pflag[`NVW_FLAG_DONE]) |->
         $past(prog_end) || $past(wr && idx == `NVW_IDX_PFLAG))
      else $error("done flag set without a finished write");
   AST_PROG_LEN: assert property (st_r.wtrig |-> st_r.prog_cnt <= PROG_LAST)
      else $error("write cycle ran past its count");
   AST_PROT_ZERO: assert property (!data_protect_fuse_i |=> prog_rdata_o == 8'h00)
      else $error("protected store visible to the programmer");

   // =================================================================
   // Cover points for the main scenarios.
   COV_WRITE_DONE: cover property (prog_end && !warm_rst);
   COV_READ: cover property (st_r.rtrig);
   COV_ABORT: cover property (warm_rst && st_r.wtrig);
   COV_NO_PERMIT: cover property (wr && idx == `NVW_IDX_CTRL && wbyte[`NVW_CTL_WR]
         && !st_r.permit);
   COV_PROTECT: cover property (!data_protect_fuse_i && st_r.prdat == 8'h00);

endmodule // nvw_ctrl

// *** tb/tb_top.sv ***
// Self-checking bench for the data nonvolatile write controller.
// Assumes nvw_ctrl and nvw_array are compiled first; timer counts are shortened.
`timescale 1ns/1ps
`include "nvw_cfg.svh"

module tb_top;
   localparam int POR_N = 80;
   localparam int PROG_N = 16;
   logic sys_clk_i;
   logic rst_i = 1'b1;
   logic ext_rst_i = 1'b0;
   logic watchdog_rst_i = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00;
   logic [3:0] wb_sel_i = 4'h1;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   logic data_protect_fuse_i = 1'b1;
   logic [7:0] prog_addr_i = 8'h00;
   logic [7:0] prog_rdata_o;
   int n_errors = 0;
   int n_checks = 0;
   logic [31:0] rv;

   nvw_ctrl #(.POR_CYCLES(POR_N), .PROG_CYCLES(PROG_N)) uut (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i), .ext_rst_i(ext_rst_i),
      .watchdog_rst_i(watchdog_rst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .data_protect_fuse_i(data_protect_fuse_i), .prog_addr_i(prog_addr_i),
      .prog_rdata_o(prog_rdata_o));

   // ================================================================
   // Clock and the closing verdict.
   initial
   begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   // ================================================================
   // Bus access: the request is held until ack is sampled; latency is checked, not relied on.
   task automatic xfer(input logic we, input logic [2:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd);
      int n;
      @(posedge sys_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= 4'h1;
      wb_adr_i <= {3'h0, idx, 2'h0};
      wb_dat_i <= {24'h0, wd};
      n = 0;
      do
      begin
         @(posedge sys_clk_i);
         n++;
      end
      while (wb_ack_o !== 1'b1);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      chk(n, 32'h2, "bus answer latency");
   endtask

   task automatic wr(input logic [2:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, d, rv);
   endtask

   task automatic expect_reg(input logic [2:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00, rv);
      chk(rv, {24'h0, exp}, "register read");
   endtask

   // ================================================================
   // Sequence helpers; gap 1 slips in a read, gap 2 an idle cycle, between the keys.
   task automatic setup(input logic [7:0] a, input logic [7:0] d);
      wr(`NVW_IDX_ADDR, a);
      wr(`NVW_IDX_DATA, d);
      wr(`NVW_IDX_CTRL, 8'h04);
   endtask

   task automatic unlock(input logic [7:0] k1, input logic [7:0] k2, input int gap,
                         input logic [7:0] ctl);
      wr(`NVW_IDX_UNLOCK, k1);
      if (gap == 1)
         xfer(1'b0, `NVW_IDX_DATA, 8'h00, rv);
      if (gap == 2)
         @(posedge sys_clk_i);
      wr(`NVW_IDX_UNLOCK, k2);
      wr(`NVW_IDX_CTRL, ctl);
   endtask

   task automatic readback(input logic [7:0] a, input logic [7:0] d);
      wr(`NVW_IDX_ADDR, a);
      wr(`NVW_IDX_DATA, ~d);
      wr(`NVW_IDX_CTRL, 8'h01);
      expect_reg(`NVW_IDX_DATA, d);
      expect_reg(`NVW_IDX_CTRL, 8'h00);
   endtask

   task automatic wait_done();
      for (int i = 0; i < 40; i++)
      begin
         xfer(1'b0, `NVW_IDX_PFLAG, 8'h00, rv);
         if (rv[7] === 1'b1)
            break;
      end
   endtask

   // A full write; clr drops the permit while the cycle runs.
   task automatic do_write(input logic [7:0] a, input logic [7:0] d, input logic clr);
      setup(a, d);
      unlock(`NVW_KEY1, `NVW_KEY2, 0, 8'h06);
      expect_reg(`NVW_IDX_CTRL, 8'h06);
      if (clr)
      begin
         wr(`NVW_IDX_CTRL, 8'h00);
         expect_reg(`NVW_IDX_CTRL, 8'h02);
      end
      wait_done();
      expect_reg(`NVW_IDX_CTRL, clr ? 8'h00 : 8'h04);
      repeat (10) @(posedge sys_clk_i);
      expect_reg(`NVW_IDX_PFLAG, 8'h80);
      wr(`NVW_IDX_PFLAG, 8'h00);
      expect_reg(`NVW_IDX_PFLAG, 8'h00);
      readback(a, d);
      $display("test write %h done", a);
   endtask

   // ================================================================
   // Scenarios.
   task automatic t_reset();
      for (int i = 0; i < 8; i++)
         expect_reg(3'(i), 8'h00);
      wr(`NVW_IDX_PENABLE, 8'hff);
      expect_reg(`NVW_IDX_PENABLE, 8'hef);
      wr(`NVW_IDX_GICTRL, 8'h80);
      expect_reg(`NVW_IDX_GICTRL, 8'h80);
      $display("test reset done");
   endtask

   task automatic t_por();
      setup(8'h10, 8'h77);
      unlock(`NVW_KEY1, `NVW_KEY2, 0, 8'h06);
      expect_reg(`NVW_IDX_CTRL, 8'h04);
      wr(`NVW_IDX_CTRL, 8'h00);
      $display("test power-up block done");
   endtask

   task automatic t_refuse();
      setup(8'h20, 8'h33);
      wr(`NVW_IDX_CTRL, 8'h00);
      unlock(`NVW_KEY1, `NVW_KEY2, 0, 8'h02);
      expect_reg(`NVW_IDX_CTRL, 8'h00);
      wr(`NVW_IDX_CTRL, 8'h04);
      unlock(`NVW_KEY2, `NVW_KEY1, 0, 8'h06);
      expect_reg(`NVW_IDX_CTRL, 8'h04);
      unlock(`NVW_KEY1, `NVW_KEY2, 1, 8'h06);
      expect_reg(`NVW_IDX_CTRL, 8'h04);
      unlock(`NVW_KEY1, `NVW_KEY2, 2, 8'h06);
      expect_reg(`NVW_IDX_CTRL, 8'h04);
      expect_reg(`NVW_IDX_PFLAG, 8'h00);
      $display("test refused starts done");
   endtask

   task automatic t_abort(input logic dog);
      setup(8'h5a, 8'h11);
      unlock(`NVW_KEY1, `NVW_KEY2, 0, 8'h06);
      @(posedge sys_clk_i);
      ext_rst_i <= ~dog;
      watchdog_rst_i <= dog;
      @(posedge sys_clk_i);
      ext_rst_i <= 1'b0;
      watchdog_rst_i <= 1'b0;
      expect_reg(`NVW_IDX_CTRL, 8'h08);
      expect_reg(`NVW_IDX_ADDR, 8'h00);
      expect_reg(`NVW_IDX_DATA, 8'h00);
      expect_reg(`NVW_IDX_PENABLE, 8'h00);
      wr(`NVW_IDX_CTRL, 8'h00);
      readback(8'h5a, 8'ha5);
      $display("test abort done");
   endtask

   task automatic t_fuse();
      prog_addr_i <= 8'hc3;
      repeat (5) @(posedge sys_clk_i);
      chk({24'h0, prog_rdata_o}, 32'h3c, "programmer read");
      data_protect_fuse_i <= 1'b0;
      repeat (5) @(posedge sys_clk_i);
      chk({24'h0, prog_rdata_o}, 32'h00, "protected read");
      readback(8'hc3, 8'h3c);
      do_write(8'h77, 8'h42, 1'b0);
      $display("test protect done");
   endtask

   // ================================================================
   // Main sequence; the timer is waited out after the early refused write.
   initial
   begin
      repeat (4) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_por();
      repeat (POR_N) @(posedge sys_clk_i);
      t_refuse();
      do_write(8'h5a, 8'ha5, 1'b1);
      do_write(8'hc3, 8'h3c, 1'b0);
      t_abort(1'b0);
      t_abort(1'b1);
      t_fuse();
      summarize();
   end

   // Watchdog: the whole run takes a few hundred cycles, this allows twenty thousand.
   initial
   begin
      #200000;
      n_errors++;
      $display("watchdog expired");
      summarize();
   end
endmodule // tb_top
